// ===== bso_pkg.sv
package bso_pkg;
  localparam logic [7:0] PH_STANDBY = 8'h0c;
  localparam logic [7:0] PH_START = 8'h0a;
  localparam logic [7:0] PH_PURGE2 = 8'h0c;
  localparam logic [7:0] PH_DIRECT = 8'h4f;
  localparam logic [7:0] PH_HOME = 8'h01;
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam int CFG_DIRECT = 0;
  localparam int CFG_CONTPURGE = 1;
  localparam int CFG_PUMPDIRECT = 2;
  localparam int CFG_CONTPILOT = 3;
  localparam int CFG_OILFROMST = 4;
  localparam int CFG_GASPDIS = 5;
  localparam int CFG_XLTEST = 6;
  localparam int CFG_PREVALARM = 7;
  localparam int CFG_VPROVE = 8;
  localparam int CFG_SEPFLAME = 9;
  localparam logic [9:0] CFG_RESET = 10'h000;
  localparam int IRQ_W = 4;
  localparam int CLK_HZ = 100_000_000;
  localparam int RUNON_S = 15;
  localparam longint RUNON_CYC = longint'(RUNON_S) * longint'(CLK_HZ);
  localparam int PHASE_MAX_US = 1000;
  localparam int PHASE_MAX_CYC = PHASE_MAX_US * (CLK_HZ / 1_000_000);
endpackage

// ===== bso_runon.sv
`timescale 1ns/1ns
`default_nettype none
// Holds its output for a fixed number of cycles after its input falls.
module bso_runon #(
  parameter int unsigned CYCLES = 1500000000
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Request and held output.
  input wire logic level_in,
  output logic held_out
);
  logic [31:0] cnt_reg;
  initial begin
    if (CYCLES < 1) $error("run-on needs at least one cycle");
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 32'h0;
      held_out <= 1'b0;
    end else if (level_in) begin
      cnt_reg <= CYCLES[31:0];
      held_out <= 1'b1;
    end else if (cnt_reg != 32'h0) begin
      cnt_reg <= cnt_reg - 32'h1;
      held_out <= (cnt_reg != 32'h1);
    end else begin
      held_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== bso_top.sv
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module bso_top #(
  parameter int unsigned RUNON_CYCLES = 32'(bso_pkg::RUNON_CYC),
  parameter int unsigned PHASE_MAX_CYCLES = 32'(bso_pkg::PHASE_MAX_CYC)
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Plant inputs, asynchronous.
  input wire logic ctrl_on_req,
  input wire logic purge_sup_in,
  input wire logic flame_in,
  input wire logic oil_low_pressure_in,
  input wire logic gas_low_pressure_in,
  input wire logic error_in,
  input wire logic prevent_start_in,
  input wire logic fan_demand_in,
  input wire logic lockout_postpurge_phase,
  input wire logic operating_in,
  input wire logic safety_time_1_done,
  input wire logic safety_time_2_done,
  input wire logic gas_pilot_oil_programs,
  input wire logic oil_fuel_in,
  // Plant outputs.
  output logic [7:0] phase_out,
  output logic fan_out,
  output logic pump_out,
  output logic pilot_out,
  output logic alarm_out,
  output logic valve_prove_out,
  output logic xlight_test_out,
  output logic oil_low_pressure_check,
  output logic gas_low_pressure_check,
  output logic [2:0] flame_sup_sel,
  output logic irq
);
  localparam int NS = 14;
  logic [NS-1:0] s1_reg, s2_reg;
  logic [NS-1:0] raw_in;
  logic on_s, sup_s, flame_s, oilp_s, gasp_s, err_s, prev_s, fan_s, lpp_s, op_s;
  logic st1_s, st2_s, gpo_s, oilf_s;
  localparam int IRQ_W_L = bso_pkg::IRQ_W;
  logic [9:0] cfg_reg, act_reg;
  logic [IRQ_W_L-1:0] stat_reg, mask_reg;
  logic start_req_reg, alarm_ack_reg;
  logic err_d_reg, suppress_reg, fan_prev_reg;
  logic [31:0] ph_cnt_reg;
  logic timeout_ev, start_ev, new_err_ev;
  logic wr, rd, runon_q;
  typedef enum logic [2:0] {SEQ_IDLE, SEQ_P10, SEQ_P12, SEQ_RUN, SEQ_HOME} bso_seq_t;
  bso_seq_t seq_reg;

  initial begin
    if (PHASE_MAX_CYCLES < 1) $error("phase maximum must be at least one cycle");
  end

  assign raw_in = {ctrl_on_req, purge_sup_in, flame_in, oil_low_pressure_in,
                   gas_low_pressure_in, error_in, prevent_start_in, fan_demand_in,
                   lockout_postpurge_phase, operating_in, safety_time_1_done,
                   safety_time_2_done, gas_pilot_oil_programs, oil_fuel_in};
  // Every plant input is asynchronous, so each passes two flip-flops first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
    end
  end
  assign {on_s, sup_s, flame_s, oilp_s, gasp_s, err_s, prev_s, fan_s, lpp_s, op_s,
          st1_s, st2_s, gpo_s, oilf_s} = s2_reg;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  // A check that passes in the last cycle still advances, so it is no timeout.
  assign timeout_ev = (seq_reg == SEQ_P10 || seq_reg == SEQ_P12) &&
                      (sup_s != act_reg[bso_pkg::CFG_CONTPURGE]) &&
                      (ph_cnt_reg == PHASE_MAX_CYCLES - 1);
  assign start_ev = start_req_reg && seq_reg == SEQ_IDLE;
  assign new_err_ev = err_s && !err_d_reg;

  // Register writes; a one clears status, but a same-cycle event wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= bso_pkg::CFG_RESET;
      mask_reg <= '0;
      stat_reg <= '0;
      start_req_reg <= 1'b0;
      alarm_ack_reg <= 1'b0;
    end else begin
      start_req_reg <= 1'b0;
      alarm_ack_reg <= 1'b0;
      if (wr && paddr == bso_pkg::ADDR_CFG) cfg_reg <= pwdata[9:0];
      if (wr && paddr == bso_pkg::ADDR_MASK) mask_reg <= pwdata[IRQ_W_L-1:0];
      if (wr && paddr == bso_pkg::ADDR_CTRL) begin
        start_req_reg <= pwdata[0];
        alarm_ack_reg <= pwdata[1];
      end
      stat_reg <= (stat_reg & ~((wr && paddr == bso_pkg::ADDR_IRQ) ?
                  pwdata[IRQ_W_L-1:0] : '0)) |
                  {prev_s && seq_reg == SEQ_IDLE, new_err_ev, start_ev, timeout_ev};
    end
  end

  // Read data is registered in setup so the access phase answers at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr inside {bso_pkg::ADDR_CFG, bso_pkg::ADDR_STAT,
                 bso_pkg::ADDR_IRQ, bso_pkg::ADDR_MASK, bso_pkg::ADDR_CTRL});
      irq <= |(stat_reg & mask_reg);
      if (rd) begin
        case (paddr)
          bso_pkg::ADDR_CFG: prdata <= {22'h0, cfg_reg};
          bso_pkg::ADDR_STAT: prdata <= {21'h0, seq_reg, phase_out};
          bso_pkg::ADDR_IRQ: prdata <= {28'h0, stat_reg};
          bso_pkg::ADDR_MASK: prdata <= {28'h0, mask_reg};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) act_reg <= bso_pkg::CFG_RESET;
    else if (start_ev) act_reg <= cfg_reg;
  end

  // Phase sequencer for the purge checks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg <= SEQ_IDLE;
      ph_cnt_reg <= 32'h0;
      phase_out <= bso_pkg::PH_HOME;
    end else begin
      case (seq_reg)
        SEQ_IDLE: begin
          ph_cnt_reg <= 32'h0;
          if (start_ev) begin
            if (cfg_reg[bso_pkg::CFG_DIRECT] && on_s) begin
              seq_reg <= SEQ_RUN;
              phase_out <= bso_pkg::PH_DIRECT;
            end else begin
              seq_reg <= SEQ_P10;
              phase_out <= bso_pkg::PH_START;
            end
          end
        end
        SEQ_P10, SEQ_P12: begin
          if (sup_s == act_reg[bso_pkg::CFG_CONTPURGE]) begin
            ph_cnt_reg <= 32'h0;
            seq_reg <= (seq_reg == SEQ_P10) ? SEQ_P12 : SEQ_RUN;
            phase_out <= (seq_reg == SEQ_P10) ? bso_pkg::PH_PURGE2 : bso_pkg::PH_DIRECT;
          end else if (timeout_ev) begin
            seq_reg <= SEQ_HOME;
            phase_out <= bso_pkg::PH_HOME;
          end else begin
            ph_cnt_reg <= ph_cnt_reg + 32'h1;
          end
        end
        SEQ_RUN: if (!on_s) begin
          seq_reg <= SEQ_HOME;
          phase_out <= bso_pkg::PH_HOME;
        end
        SEQ_HOME: seq_reg <= SEQ_IDLE;
        default: seq_reg <= SEQ_IDLE;
      endcase
    end
  end

  // Pump run-on timer.
  bso_runon #(.CYCLES(RUNON_CYCLES)) u_runon (
    .pclk(pclk),
    .presetn(presetn),
    .level_in(fan_s && act_reg[bso_pkg::CFG_PUMPDIRECT]),
    .held_out(runon_q)
  );

  // Plant outputs, all registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fan_out <= 1'b0;
      fan_prev_reg <= 1'b0;
      pump_out <= 1'b0;
      pilot_out <= 1'b0;
      valve_prove_out <= 1'b0;
      xlight_test_out <= 1'b0;
      oil_low_pressure_check <= 1'b0;
      gas_low_pressure_check <= 1'b0;
      flame_sup_sel <= 3'h0;
    end else begin
      fan_out <= lpp_s ? fan_prev_reg : fan_s;
      if (!lpp_s) fan_prev_reg <= fan_s;
      pump_out <= runon_q;
      pilot_out <= !op_s ? 1'b0 : act_reg[bso_pkg::CFG_CONTPILOT];
      valve_prove_out <= act_reg[bso_pkg::CFG_VPROVE] && seq_reg == SEQ_P10;
      xlight_test_out <= act_reg[bso_pkg::CFG_XLTEST] && seq_reg == SEQ_IDLE && flame_s;
      oil_low_pressure_check <= oilp_s && (!act_reg[bso_pkg::CFG_OILFROMST] ||
                                (gpo_s ? st2_s : st1_s));
      gas_low_pressure_check <= gasp_s && !(act_reg[bso_pkg::CFG_GASPDIS] && gpo_s);
      flame_sup_sel <= act_reg[bso_pkg::CFG_SEPFLAME] ?
                       {oilf_s, op_s, seq_reg == SEQ_IDLE} : 3'h0;
    end
  end

  // Alarm output with one-shot suppression.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_d_reg <= 1'b0;
      suppress_reg <= 1'b0;
      alarm_out <= 1'b0;
    end else begin
      err_d_reg <= err_s;
      if (new_err_ev || !err_s) suppress_reg <= 1'b0;
      else if (alarm_ack_reg) suppress_reg <= 1'b1;
      alarm_out <= (err_s && !suppress_reg && !new_err_ev) || (err_s && new_err_ev) ||
                   (prev_s && act_reg[bso_pkg::CFG_PREVALARM]);
    end
  end

  pump_fan_a: assert property (@(posedge pclk) disable iff (!presetn)
    act_reg[bso_pkg::CFG_PUMPDIRECT] && fan_s |-> ##2 pump_out)
    else $error("pump off while fan runs");
  purge_tout_a: assert property (@(posedge pclk) disable iff (!presetn)
    timeout_ev |=> phase_out == bso_pkg::PH_HOME)
    else $error("purge timeout did not return to phase 01");
  direct_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    start_ev && cfg_reg[bso_pkg::CFG_DIRECT] && on_s |=> phase_out == bso_pkg::PH_DIRECT)
    else $error("direct start did not enter phase 79");
  new_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    new_err_ev |=> alarm_out)
    else $error("new error not alarmed");
  prove_p10_a: assert property (@(posedge pclk) disable iff (!presetn)
    valve_prove_out |-> $past(seq_reg) == SEQ_P10)
    else $error("valve proving outside phase 10");
  gas_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    act_reg[bso_pkg::CFG_GASPDIS] && gpo_s && $stable(act_reg) |=> !gas_low_pressure_check)
    else $error("gas check not disabled");
  cfg_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !start_ev |=> $stable(act_reg))
    else $error("options changed mid sequence");
  cont_purge_a: assert property (@(posedge pclk) disable iff (!presetn)
    seq_reg == SEQ_P10 && sup_s == act_reg[bso_pkg::CFG_CONTPURGE] |=> seq_reg == SEQ_P12)
    else $error("purge check did not advance");
endmodule
`default_nettype wire

// ===== bso_plant.sv
`timescale 1ns/1ns
`default_nettype none
// Far side of the sequencer: purge supervision switch, flame detector, pressure switches.
module bso_plant (
  // Controller outputs seen by the plant.
  input wire logic pump_out,
  // Scenario commands.
  input wire logic sup_cmd,
  input wire logic flame_cmd,
  input wire logic gas_fault_cmd,
  // Switch and detector levels.
  output logic purge_sup_in,
  output logic flame_in,
  output logic oil_low_pressure_in,
  output logic gas_low_pressure_in
);
  assign purge_sup_in = sup_cmd;
  assign flame_in = flame_cmd;
  // Oil pressure collapses as soon as the pump stops, so the low switch trips.
  assign oil_low_pressure_in = !pump_out;
  assign gas_low_pressure_in = gas_fault_cmd;
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, fan_out, pump_out, pilot_out, alarm_out, valve_prove_out, irq;
  logic xlight_test_out, oil_low_pressure_check, gas_low_pressure_check;
  logic [7:0] phase_out;
  logic [2:0] flame_sup_sel;
  logic ctrl_on_req = 1'b0, error_in = 1'b0, prevent_start_in = 1'b0, fan_demand_in = 1'b0;
  logic lockout_postpurge_phase = 1'b0, operating_in = 1'b0, safety_time_1_done = 1'b0;
  logic safety_time_2_done = 1'b0, gas_pilot_oil_programs = 1'b0, oil_fuel_in = 1'b0;
  logic sup_cmd = 1'b0, flame_cmd = 1'b0, gas_fault_cmd = 1'b0;
  logic purge_sup_in, flame_in, oil_low_pressure_in, gas_low_pressure_in;
  logic [32:0] exp_q[$];
  int fails = 0;
  int num_checks = 0;

  bso_top #(.RUNON_CYCLES(20), .PHASE_MAX_CYCLES(10)) i_bso_top (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ctrl_on_req,
    .purge_sup_in, .flame_in, .oil_low_pressure_in, .gas_low_pressure_in, .error_in,
    .prevent_start_in, .fan_demand_in, .lockout_postpurge_phase, .operating_in,
    .safety_time_1_done, .safety_time_2_done, .gas_pilot_oil_programs, .oil_fuel_in,
    .phase_out, .fan_out, .pump_out, .pilot_out, .alarm_out, .valve_prove_out,
    .xlight_test_out, .oil_low_pressure_check, .gas_low_pressure_check, .flame_sup_sel, .irq);
  bso_plant i_bso_plant (.pump_out, .sup_cmd, .flame_cmd, .gas_fault_cmd, .purge_sup_in,
    .flame_in, .oil_low_pressure_in, .gas_low_pressure_in);

  always #5 pclk = ~pclk;

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Read results are compared by the watcher below, oldest note first.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      chk({pslverr, prdata}, exp_q.pop_front());
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      $display("ERROR %0t bus answer missing", $time);
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Let one edge pass so a following call never reassigns psel in this step.
    @(posedge pclk);
  endtask

  function automatic logic [7:0] pick(input int s);
    case (s)
      0: return phase_out;
      1: return {7'h00, pump_out};
      2: return {7'h00, alarm_out};
      3: return {7'h00, irq};
      4: return {7'h00, pilot_out};
      6: return {7'h00, gas_low_pressure_check};
      7: return {7'h00, fan_out};
      8: return {7'h00, valve_prove_out};
      9: return {7'h00, xlight_test_out};
      10: return {5'h00, flame_sup_sel};
      default: return {7'h00, oil_low_pressure_check};
    endcase
  endfunction

  task automatic wait_out(input int s, input logic [7:0] v, input int bound);
    int n;
    n = 0;
    while (pick(s) !== v && n < bound) begin
      @(posedge pclk);
      n++;
    end
    if (pick(s) !== v) begin
      fails++;
      $display("ERROR %0t output %0d never reached %h", $time, s, v);
      end_sim();
    end
    chk({25'h0, pick(s)}, {25'h0, v});
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  task automatic start(input logic [31:0] cfg);
    do_reset();
    apb(1'b1, bso_pkg::ADDR_CFG, cfg, 33'h0);
    apb(1'b1, bso_pkg::ADDR_CTRL, 32'h1, 33'h0);
  endtask

  initial begin
    logic [9:0] c;
    logic [7:0] a;
    int n;
    void'($urandom(25000));
    do_reset();
    chk({25'h0, phase_out}, {25'h0, bso_pkg::PH_HOME});
    apb(1'b0, bso_pkg::ADDR_MASK, 32'h0, 33'h0);
    repeat (4) begin
      c = 10'($urandom);
      a = 8'(20 + 4 * $urandom_range(58));
      apb(1'b1, bso_pkg::ADDR_CFG, {22'h0, c}, 33'h0);
      apb(1'b0, bso_pkg::ADDR_CFG, 32'h0, {11'h0, 12'h0, c});
      apb(1'b1, a, 32'hffffffff, 33'h0);
      apb(1'b0, a, 32'h0, {1'b1, 32'h0});
    end
    start(32'h0);
    wait_out(0, bso_pkg::PH_START, 20);
    wait_out(0, bso_pkg::PH_DIRECT, 40);
    for (int m = 0; m < 2; m++) begin
      sup_cmd <= ~m[0];
      do_reset();
      apb(1'b1, bso_pkg::ADDR_MASK, 32'h1, 33'h0);
      apb(1'b1, bso_pkg::ADDR_CFG, 32'(m << 1), 33'h0);
      apb(1'b1, bso_pkg::ADDR_CTRL, 32'h1, 33'h0);
      wait_out(0, bso_pkg::PH_START, 20);
      wait_out(0, bso_pkg::PH_HOME, 60);
      wait_out(3, 8'h01, 5);
      apb(1'b0, bso_pkg::ADDR_IRQ, 32'h0, 33'h3);
      apb(1'b1, bso_pkg::ADDR_IRQ, 32'h3, 33'h0);
      wait_out(3, 8'h00, 5);
    end
    sup_cmd <= 1'b0;
    ctrl_on_req <= 1'b1;
    start(32'h1);
    wait_out(0, bso_pkg::PH_DIRECT, 20);
    oil_fuel_in <= 1'b1;
    start(32'h1c);
    wait_out(5, 8'h00, 10);
    safety_time_1_done <= 1'b1;
    wait_out(5, 8'h01, 10);
    operating_in <= 1'b1;
    wait_out(4, 8'h01, 10);
    fan_demand_in <= 1'b1;
    wait_out(1, 8'h01, 20);
    fan_demand_in <= 1'b0;
    n = 0;
    while (pump_out === 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk({32'h0, n >= 20 && n <= 30}, 33'h1);
    error_in <= 1'b1;
    wait_out(2, 8'h01, 10);
    apb(1'b1, bso_pkg::ADDR_CTRL, 32'h2, 33'h0);
    wait_out(2, 8'h00, 10);
    error_in <= 1'b0;
    repeat (5) @(posedge pclk);
    error_in <= 1'b1;
    wait_out(2, 8'h01, 10);
    error_in <= 1'b0;
    ctrl_on_req <= 1'b0;
    start(32'h80);
    prevent_start_in <= 1'b1;
    wait_out(2, 8'h01, 10);
    gas_fault_cmd <= 1'b1;
    flame_cmd <= 1'b1;
    gas_pilot_oil_programs <= 1'b1;
    start(32'h360);
    wait_out(8, 8'h01, 10);
    wait_out(6, 8'h00, 20);
    gas_pilot_oil_programs <= 1'b0;
    wait_out(6, 8'h01, 10);
    wait_out(9, 8'h01, 20);
    wait_out(10, 8'h07, 20);
    fan_demand_in <= 1'b1;
    wait_out(7, 8'h01, 10);
    lockout_postpurge_phase <= 1'b1;
    fan_demand_in <= 1'b0;
    repeat (6) @(posedge pclk);
    chk({32'h0, fan_out}, 33'h1);
    end_sim();
  end
endmodule
`default_nettype wire
